//--- pkg/status_query_pkg.sv
package status_query_pkg;

    // =====================================================
    // timing
    localparam int CLK_NS         = 10;
    localparam int BAUD_RATE      = 2400;
    localparam int BIT_NS         = 1_000_000_000 / BAUD_RATE;
    localparam int BIT_CYCLES_DEF = BIT_NS / CLK_NS;

    // =====================================================
    // characters
    localparam logic [7:0] CHAR_CR    = 8'h0d;
    localparam logic [7:0] CHAR_LF    = 8'h0a;
    localparam logic [7:0] CHAR_ZERO  = 8'h30;
    localparam logic [7:0] CHAR_NINE  = 8'h39;
    localparam logic [7:0] CHAR_DOT   = 8'h2e;
    localparam logic [7:0] CHAR_PLUS  = 8'h2b;
    localparam logic [7:0] CHAR_MINUS = 8'h2d;
    localparam logic [7:0] CHAR_L     = 8'h4c;
    localparam logic [7:0] CHAR_V     = 8'h56;
    localparam logic [7:0] CHAR_A     = 8'h41;
    localparam logic [7:0] CHAR_W     = 8'h57;
    localparam logic [7:0] CHAR_U     = 8'h55;
    localparam logic [7:0] CHAR_I     = 8'h49;
    localparam logic [7:0] CHAR_P     = 8'h50;
    localparam logic [7:0] CHAR_F     = 8'h46;
    localparam logic [7:0] CHAR_S     = 8'h53;
    localparam logic [7:0] CHAR_M     = 8'h4d;
    localparam logic [7:0] LOWER_BIT  = 8'h20;

    // =====================================================
    // reply frame: group start positions and full frame length
    localparam logic [5:0] POS_V = 6'h00;
    localparam logic [5:0] POS_A = 6'h06;
    localparam logic [5:0] POS_W = 6'h0c;
    localparam logic [5:0] POS_U = 6'h12;
    localparam logic [5:0] POS_I = 6'h15;
    localparam logic [5:0] POS_P = 6'h1a;
    localparam logic [5:0] POS_F = 6'h1e;
    localparam logic [5:0] FULL_LEN = 6'h25;

    // =====================================================
    // register map
    localparam logic [7:0] ADDR_VOUT = 8'h00;
    localparam logic [7:0] ADDR_IOUT = 8'h04;
    localparam logic [7:0] ADDR_POUT = 8'h08;
    localparam logic [7:0] ADDR_ULIM = 8'h0c;
    localparam logic [7:0] ADDR_ILIM = 8'h10;
    localparam logic [7:0] ADDR_PLIM = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;
    localparam logic [7:0] ADDR_CMD  = 8'h1c;
    localparam int CMD_VALID_BIT = 8;
    localparam int CMD_BUSY_BIT  = 9;
    localparam int CMD_DROP_BIT  = 10;
    localparam int STAT_EDIT_LSB = 8;

    typedef struct packed {
        logic lock;
        logic remote_mode_flag;
        logic unlocked;
        logic fine;
        logic overheat;
        logic relay_on;
    } flags_type;

    // edit: bit0 voltage limit, bit1 current limit, bit2 power limit
    typedef struct packed {
        logic [15:0] vout;
        logic [15:0] iout;
        logic [15:0] pout;
        logic [7:0]  ulim;
        logic [11:0] ilim;
        logic [11:0] plim;
        flags_type   flags;
        logic [2:0]  edit;
    } readings_type;

    localparam readings_type READINGS_RST = '0;

endpackage : status_query_pkg

//--- rtl/serial_rx.sv
`timescale 1ns/1ps
module serial_rx
    import status_query_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
    input  wire logic       hclk,      // system clock
    input  wire logic       hresetn,   // async reset
    input  wire logic       rxd,       // serial line in
    output logic      [7:0] rx_data,   // received byte
    output logic            rx_valid   // byte strobe
);
    localparam int CW = $clog2(BIT_CYCLES + 1);
    localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);
    localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2);

    typedef enum logic [0:0] {R_IDLE = 1'b0, R_RUN = 1'b1} rx_state_type;

    rx_state_type  state, next_state;
    logic [CW-1:0] cnt, next_cnt;
    logic [3:0]    bitn, next_bitn;
    logic [7:0]    shift, next_shift;
    logic [7:0]    next_rx_data;
    logic          next_rx_valid;

    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_bitn     = bitn;
        next_shift    = shift;
        next_rx_data  = rx_data;
        next_rx_valid = 1'b0;
        unique case (state)
            R_IDLE: begin
                if (!rxd) begin
                    next_state = R_RUN;
                    next_cnt   = HALF;
                    next_bitn  = 4'h0;
                end
            end
            R_RUN: begin
                if (cnt != '0) begin
                    next_cnt = cnt - 1'b1;
                end else begin
                    next_cnt  = FULL;
                    next_bitn = bitn + 4'h1;
                    if (bitn == 4'h0 && rxd) begin
                        next_state = R_IDLE;
                    end else if (bitn >= 4'h1 && bitn <= 4'h8) begin
                        next_shift = {rxd, shift[7:1]};
                    end else if (bitn == 4'h9) begin
                        next_state = R_IDLE;
                        // broken stop bit drops the byte
                        if (rxd) begin
                            next_rx_data  = shift;
                            next_rx_valid = 1'b1;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state    <= R_IDLE;
            cnt      <= '0;
            bitn     <= 4'h0;
            shift    <= 8'h00;
            rx_data  <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            bitn     <= next_bitn;
            shift    <= next_shift;
            rx_data  <= next_rx_data;
            rx_valid <= next_rx_valid;
        end
    end

endmodule : serial_rx

//--- rtl/serial_tx.sv
`timescale 1ns/1ps
module serial_tx
    import status_query_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
    input  wire logic       hclk,      // system clock
    input  wire logic       hresetn,   // async reset
    input  wire logic [7:0] tx_data,   // byte to send
    input  wire logic       tx_valid,  // byte offered
    output logic            tx_ready,  // idle, byte taken
    output logic            txd        // serial line out
);
    localparam int CW = $clog2(BIT_CYCLES + 1);
    localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);

    typedef enum logic [0:0] {T_IDLE = 1'b0, T_RUN = 1'b1} tx_state_type;

    tx_state_type  state, next_state;
    logic [CW-1:0] cnt, next_cnt;
    logic [3:0]    bitn, next_bitn;
    logic [9:0]    shift, next_shift;
    logic          next_txd;
    logic          bit_tick;

    assign tx_ready = (state == T_IDLE);
    assign bit_tick = (cnt == '0);

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_bitn  = bitn;
        next_shift = shift;
        next_txd   = txd;
        unique case (state)
            T_IDLE: begin
                next_txd = 1'b1;
                if (tx_valid) begin
                    next_shift = {1'b1, tx_data, 1'b0};
                    next_state = T_RUN;
                    next_cnt   = '0;
                    next_bitn  = 4'h0;
                end
            end
            T_RUN: begin
                next_cnt = bit_tick ? FULL : cnt - 1'b1;
                if (bit_tick) begin
                    if (bitn == 4'ha) begin
                        next_state = T_IDLE;
                    end else begin
                        next_txd   = shift[0];
                        next_shift = {1'b1, shift[9:1]};
                        next_bitn  = bitn + 4'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= T_IDLE;
            cnt   <= '0;
            bitn  <= 4'h0;
            shift <= 10'h3ff;
            txd   <= 1'b1;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            bitn  <= next_bitn;
            shift <= next_shift;
            txd   <= next_txd;
        end
    end

endmodule : serial_tx

//--- rtl/serial_status_query_responder.sv
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module serial_status_query_responder
    import status_query_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
    input  wire logic        hclk,       // system clock
    input  wire logic        hresetn,    // async reset, active low
    input  wire logic        hsel,       // slave select
    input  wire logic [31:0] haddr,      // byte address
    input  wire logic [1:0]  htrans,     // transfer type
    input  wire logic        hwrite,     // write transfer
    input  wire logic [2:0]  hsize,      // transfer size
    input  wire logic [31:0] hwdata,     // write data
    input  wire logic        hready,     // bus ready
    output logic             hreadyout,  // slave ready
    output logic             hresp,      // always okay
    output logic      [31:0] hrdata,     // read data
    input  wire logic        rxd,        // serial from host
    output logic             txd         // serial to host
);

    // =====================================================
    // helpers
    // clamp to a decimal digit
    function automatic logic [7:0] digit(input logic [3:0] nib);
        digit = (nib > 4'h9) ? CHAR_NINE : (CHAR_ZERO | {4'h0, nib});
    endfunction : digit

    function automatic logic [7:0] bit_digit(input logic b);
        bit_digit = CHAR_ZERO | {7'h00, b};
    endfunction : bit_digit

    function automatic logic [7:0] tag(input logic [7:0] c, input logic low);
        tag = low ? (c | LOWER_BIT) : c;
    endfunction : tag

    function automatic logic [7:0] char_at(input readings_type r, input logic [5:0] i);
        unique case (i)
            6'h00: char_at = CHAR_V;
            6'h01: char_at = digit(r.vout[15:12]);
            6'h02: char_at = digit(r.vout[11:8]);
            6'h03: char_at = CHAR_DOT;
            6'h04: char_at = digit(r.vout[7:4]);
            6'h05: char_at = digit(r.vout[3:0]);
            6'h06: char_at = CHAR_A;
            6'h07: char_at = digit(r.iout[15:12]);
            6'h08: char_at = CHAR_DOT;
            6'h09: char_at = digit(r.iout[11:8]);
            6'h0a: char_at = digit(r.iout[7:4]);
            6'h0b: char_at = digit(r.iout[3:0]);
            6'h0c: char_at = CHAR_W;
            6'h0d: char_at = digit(r.pout[15:12]);
            6'h0e: char_at = digit(r.pout[11:8]);
            6'h0f: char_at = digit(r.pout[7:4]);
            6'h10: char_at = CHAR_DOT;
            6'h11: char_at = digit(r.pout[3:0]);
            6'h12: char_at = tag(CHAR_U, r.edit[0]);
            6'h13: char_at = digit(r.ulim[7:4]);
            6'h14: char_at = digit(r.ulim[3:0]);
            6'h15: char_at = tag(CHAR_I, r.edit[1]);
            6'h16: char_at = digit(r.ilim[11:8]);
            6'h17: char_at = CHAR_DOT;
            6'h18: char_at = digit(r.ilim[7:4]);
            6'h19: char_at = digit(r.ilim[3:0]);
            6'h1a: char_at = tag(CHAR_P, r.edit[2]);
            6'h1b: char_at = digit(r.plim[11:8]);
            6'h1c: char_at = digit(r.plim[7:4]);
            6'h1d: char_at = digit(r.plim[3:0]);
            6'h1e: char_at = CHAR_F;
            6'h1f: char_at = bit_digit(r.flags.relay_on);
            6'h20: char_at = bit_digit(r.flags.overheat);
            6'h21: char_at = bit_digit(r.flags.fine);
            6'h22: char_at = bit_digit(r.flags.unlocked);
            6'h23: char_at = bit_digit(r.flags.remote_mode_flag);
            6'h24: char_at = bit_digit(r.flags.lock);
            default: char_at = CHAR_ZERO;
        endcase
    endfunction : char_at

    // =====================================================
    // serial ends
    logic [7:0] rx_data;
    logic       rx_valid;
    logic [7:0] tx_data;
    logic       tx_valid;
    logic       tx_ready;

    // both ends share one bit period; only the transmitter has a valid/ready handshake
    serial_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .rxd      (rxd),
        .rx_data  (rx_data),
        .rx_valid (rx_valid)
    );

    serial_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .tx_data  (tx_data),
        .tx_valid (tx_valid),
        .tx_ready (tx_ready),
        .txd      (txd)
    );

    // =====================================================
    // command line parser
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_BODY = 2'b01,
        S_CR   = 2'b10,
        S_LF   = 2'b11
    } send_state_type;

    send_state_type send, next_send;
    logic [7:0]     line [3];
    logic [7:0]     next_line [3];
    logic [1:0]     fill, next_fill;
    logic           overlong, next_overlong;
    logic [5:0]     idx, next_idx;
    logic [5:0]     last, next_last;
    readings_type   regs, next_regs;
    readings_type   snap, next_snap;
    logic [4:0]     cmd_code, next_cmd_code;
    logic           cmd_valid, next_cmd_valid;
    logic           dropped, next_dropped;

    logic           is_query;
    logic [5:0]     q_pos;
    logic [5:0]     q_len;
    logic           is_set;
    logic [1:0]     set_var;
    logic [1:0]     set_op;

    always_comb begin
        is_query = 1'b0;
        q_pos    = POS_V;
        q_len    = 6'h06;
        is_set   = 1'b0;
        set_var  = 2'b00;
        set_op   = 2'b00;
        if (!overlong && fill == 2'h1) begin
            is_query = 1'b1;
            unique case (line[0])
                CHAR_L: begin q_pos = POS_V; q_len = FULL_LEN; end
                CHAR_V: begin q_pos = POS_V; q_len = 6'h06; end
                CHAR_A: begin q_pos = POS_A; q_len = 6'h06; end
                CHAR_W: begin q_pos = POS_W; q_len = 6'h06; end
                CHAR_U: begin q_pos = POS_U; q_len = 6'h03; end
                CHAR_I: begin q_pos = POS_I; q_len = 6'h05; end
                CHAR_P: begin q_pos = POS_P; q_len = 6'h04; end
                CHAR_F: begin q_pos = POS_F; q_len = 6'h07; end
                default: is_query = 1'b0;
            endcase
        end
        if (!overlong && fill == 2'h3 && line[0] == CHAR_S) begin
            is_set = 1'b1;
            unique case (line[1])
                CHAR_V: set_var = 2'h0;
                CHAR_U: set_var = 2'h1;
                CHAR_I: set_var = 2'h2;
                CHAR_P: set_var = 2'h3;
                default: is_set = 1'b0;
            endcase
            unique case (line[2])
                CHAR_PLUS:  set_op = 2'h0;
                CHAR_MINUS: set_op = 2'h1;
                CHAR_M:     set_op = 2'h2;
                default:    is_set = 1'b0;
            endcase
        end
    end

    // =====================================================
    // bus slave
    logic        acc;
    logic        wr_q;
    logic [7:0]  addr_q;
    logic [31:0] next_hrdata;
    logic        wr_en;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign acc       = hsel & htrans[1] & hready;
    assign wr_en     = wr_q;

    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (acc && !hwrite) begin
            unique case (haddr[7:0])
                ADDR_VOUT: next_hrdata = {16'h0000, regs.vout};
                ADDR_IOUT: next_hrdata = {16'h0000, regs.iout};
                ADDR_POUT: next_hrdata = {16'h0000, regs.pout};
                ADDR_ULIM: next_hrdata = {24'h000000, regs.ulim};
                ADDR_ILIM: next_hrdata = {20'h00000, regs.ilim};
                ADDR_PLIM: next_hrdata = {20'h00000, regs.plim};
                ADDR_STAT: next_hrdata = {21'h000000, regs.edit, 2'b00, regs.flags};
                ADDR_CMD:  next_hrdata = {21'h000000, dropped, send != S_IDLE,
                                          cmd_valid, 3'b000, cmd_code};
                default:   next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // =====================================================
    // main next-state
    always_comb begin
        next_send      = send;
        next_line      = line;
        next_fill      = fill;
        next_overlong  = overlong;
        next_idx       = idx;
        next_last      = last;
        next_regs      = regs;
        next_snap      = snap;
        next_cmd_code  = cmd_code;
        next_cmd_valid = cmd_valid;
        next_dropped   = dropped;
        tx_valid       = (send != S_IDLE);
        tx_data        = char_at(snap, idx);

        if (wr_en) begin
            unique case (addr_q)
                ADDR_VOUT: next_regs.vout  = hwdata[15:0];
                ADDR_IOUT: next_regs.iout  = hwdata[15:0];
                ADDR_POUT: next_regs.pout  = hwdata[15:0];
                ADDR_ULIM: next_regs.ulim  = hwdata[7:0];
                ADDR_ILIM: next_regs.ilim  = hwdata[11:0];
                ADDR_PLIM: next_regs.plim  = hwdata[11:0];
                ADDR_STAT: begin
                    next_regs.flags = flags_type'(hwdata[5:0]);
                    next_regs.edit  = hwdata[STAT_EDIT_LSB +: 3];
                end
                ADDR_CMD: begin
                    if (hwdata[CMD_VALID_BIT]) next_cmd_valid = 1'b0;
                    if (hwdata[CMD_DROP_BIT])  next_dropped   = 1'b0;
                end
                default: ;
            endcase
        end

        // body, then carriage return and line feed
        unique case (send)
            S_IDLE: tx_data = CHAR_CR;
            S_BODY: if (tx_ready) begin
                next_idx = idx + 6'h01;
                if (idx == last) next_send = S_CR;
            end
            S_CR: begin
                tx_data = CHAR_CR;
                if (tx_ready) next_send = S_LF;
            end
            S_LF: begin
                tx_data = CHAR_LF;
                if (tx_ready) next_send = S_IDLE;
            end
        endcase

        if (rx_valid) begin
            if (rx_data == CHAR_CR) begin
                next_fill     = 2'h0;
                next_overlong = 1'b0;
                // reply starts at once; snapshot keeps the record consistent
                if (is_query && send == S_IDLE) begin
                    next_send = S_BODY;
                    next_idx  = q_pos;
                    next_last = q_pos + q_len - 6'h01;
                    next_snap = regs;
                end else if (is_query) begin
                    next_dropped = 1'b1;
                end
                if (is_set && regs.flags.remote_mode_flag) begin
                    next_cmd_code  = {1'b1, set_var, set_op};
                    next_cmd_valid = 1'b1;
                end
                // unknown line is dropped without reply
                if (!is_query && !is_set) begin
                    next_dropped = 1'b1;
                end
            // line feed after the terminator is ignored
            end else if (!(rx_data == CHAR_LF && fill == 2'h0)) begin
                if (fill == 2'h3) begin
                    next_overlong = 1'b1;
                end else begin
                    next_line[fill] = rx_data;
                    next_fill       = fill + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            send      <= S_IDLE;
            line      <= '{default: 8'h00};
            fill      <= 2'h0;
            overlong  <= 1'b0;
            idx       <= 6'h00;
            last      <= 6'h00;
            regs      <= READINGS_RST;
            snap      <= READINGS_RST;
            cmd_code  <= 5'h00;
            cmd_valid <= 1'b0;
            dropped   <= 1'b0;
            wr_q      <= 1'b0;
            addr_q    <= 8'h00;
            hrdata    <= 32'h0000_0000;
        end else begin
            send      <= next_send;
            line      <= next_line;
            fill      <= next_fill;
            overlong  <= next_overlong;
            idx       <= next_idx;
            last      <= next_last;
            regs      <= next_regs;
            snap      <= next_snap;
            cmd_code  <= next_cmd_code;
            cmd_valid <= next_cmd_valid;
            dropped   <= next_dropped;
            wr_q      <= acc & hwrite;
            addr_q    <= haddr[7:0];
            hrdata    <= next_hrdata;
        end
    end

endmodule : serial_status_query_responder

//--- tb/serial_status_query_responder_properties.sv
`timescale 1ns/1ps
module serial_status_query_responder_properties
    import status_query_pkg::*;
#(parameter int BIT_CYCLES = BIT_CYCLES_DEF) (
    input wire logic        hclk,      // clock
    input wire logic        hresetn,   // reset
    input wire logic        hsel,      // select
    input wire logic [31:0] haddr,     // address
    input wire logic [1:0]  htrans,    // type
    input wire logic        hwrite,    // write
    input wire logic        hready,    // ready in
    input wire logic        hreadyout, // ready out
    input wire logic        hresp,     // response
    input wire logic [31:0] hrdata,    // read data
    input wire logic        txd        // serial out
);
    int fcnt;
    // cycles since the start bit fell, zero between frames
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) fcnt <= 0;
        else if (fcnt == 10 * BIT_CYCLES - 1) fcnt <= 0;
        else if (fcnt != 0 || !txd) fcnt <= fcnt + 1;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_in_bit;
        fcnt != 0 && fcnt % BIT_CYCLES != 0;
    endsequence
    AST_READY: assert property (hreadyout) else $error("bus stalled");
    AST_OKAY: assert property (!hresp) else $error("error response");
    AST_IDLE_ZERO: assert property (
        !(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0) else $error("stale data");
    AST_UNMAPPED: assert property (
        s_rd ##0 haddr[7:5] != 3'h0 |=> hrdata == 32'h0) else $error("unmapped not zero");
    AST_TX_IDLE: assert property ($rose(hresetn) |-> txd) else $error("line not idle");
    AST_START: assert property (
        fcnt != 0 && fcnt < BIT_CYCLES |-> !txd) else $error("short start bit");
    AST_STOP: assert property (
        fcnt >= 9 * BIT_CYCLES |-> txd) else $error("bad stop bit");
    AST_BIT_TIME: assert property (
        s_in_bit |-> $stable(txd)) else $error("bit time broken");
endmodule : serial_status_query_responder_properties
bind serial_status_query_responder serial_status_query_responder_properties #(
    .BIT_CYCLES(BIT_CYCLES)) u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .txd(txd));

//--- tb/host_serial_port.sv
`timescale 1ns/1ps
module host_serial_port
    import status_query_pkg::*;
#(parameter int BIT_CYCLES = BIT_CYCLES_DEF) (
    input wire logic hclk, // clock
    input wire logic txd,  // from device
    output logic     rxd   // to device
);
    logic [7:0] rx_q[$];
    logic [7:0] b;
    initial rxd = 1'b1;
    task automatic send_byte(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge hclk);
            rxd <= f[i];
            repeat (BIT_CYCLES - 1) @(posedge hclk);
        end
    endtask : send_byte
    // mid-bit sampling, bad stop drops byte
    always begin
        @(negedge txd);
        repeat (BIT_CYCLES / 2) @(posedge hclk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CYCLES) @(posedge hclk);
            if (i < 8) b[i] = txd;
            else if (txd) rx_q.push_back(b);
        end
    end
endmodule : host_serial_port

//--- tb/serial_status_query_responder_tb_top.sv
`timescale 1ns/1ps
module serial_status_query_responder_tb_top;
    import status_query_pkg::*;
    localparam int BC = 16;
    logic        hclk, hsel, hwrite, hreadyout, hresp, rxd, txd;
    logic        hresetn = 1'b0;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata;
    int          errors, checks_done, cyc;
    logic [31:0] vals [7] = '{32'h2000, 32'h2500, 32'h0500, 32'h40, 32'h500, 32'h200, 32'h5};
    string       r1 = "V20.00A2.500W050.0U40I5.00P200F101000\015\012";
    string       r2 = "V20.00A2.500W050.0u40i5.00p200F010111\015\012";
    serial_status_query_responder #(.BIT_CYCLES(BC)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rxd(rxd), .txd(txd));
    host_serial_port #(.BIT_CYCLES(BC)) u_host (.hclk(hclk), .txd(txd), .rxd(rxd));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // read compares masked data against d
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, m);
        @(posedge hclk);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        if (!w) chk(hrdata & m, d & m);
    endtask : bus
    task automatic cmd(input string s, input string exp);
        for (int i = 0; i < s.len(); i++) u_host.send_byte(s[i]);
        for (int i = 0; i < 9000 && u_host.rx_q.size() < exp.len(); i++) @(posedge hclk);
        repeat (BC * 20) @(posedge hclk);
        chk(32'(u_host.rx_q.size()), 32'(exp.len()));
        foreach (u_host.rx_q[i]) chk({24'h0, u_host.rx_q[i]}, {24'h0, exp[i]});
        u_host.rx_q.delete();
        $display("test done at %0t", $time);
    endtask : cmd
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        foreach (vals[i]) bus(8'(4 * i), 0, 0, '1);
        bus(8'h40, 0, 0, '1);
        foreach (vals[i]) bus(8'(4 * i), 1, vals[i], 0);
        foreach (vals[i]) bus(8'(4 * i), 0, vals[i], '1);
        cmd("L\015", r1);
        bus(8'h18, 1, 32'h73a, 0);
        cmd("L\015\012", r2);
        cmd("L\015", r2);
        cmd("U\015", "u40\015\012");
        cmd("I\015\012", "i5.00\015\012");
        cmd("F\015", "F010111\015\012");
        bus(8'h00, 1, 32'hfa00, 0);
        cmd("V\015", "V99.00\015\012");
        cmd("LLLL\015", "");
        cmd("X\015", "");
        bus(8'h1c, 0, 32'h400, 32'h400);
        bus(8'h1c, 1, 32'h500, 0);
        bus(8'h18, 1, 32'h0, 0);
        cmd("SV+\015", "");
        bus(8'h1c, 0, 0, 32'h100);
        bus(8'h18, 1, 32'h10, 0);
        cmd("SV+\015", "");
        bus(8'h1c, 0, 32'h110, 32'h11f);
        cmd("SPM\015", "");
        bus(8'h1c, 0, 32'h11e, 32'h11f);
        wrap_up();
    end
endmodule : serial_status_query_responder_tb_top
